// ==== rtl/pfls_bank.sv ====
`include "pfls_map.svh"
module pfls_bank
   import pfls_pkg::*;
#(
   parameter logic [15:0] LOWLINE_CUR_LIMIT = 16'h0200,
   parameter logic [15:0] LOWLINE_CUR_WARN = 16'h01C0,
   parameter logic [15:0] LOW_OUT_THRESH = 16'h0100
) (
   // clock, reset, enable
   input wire logic sys_clk_i,
   input wire logic arst_n_i,
   input wire logic ce_i,
   // command port
   input wire pfls_cmd_t cmd_i,
   input wire logic in_control_i,
   output logic [15:0] rdata_o,
   output logic rvalid_o,
   // measurements and line state
   input wire pfls_meas_t meas_i,
   input wire logic high_line_i,
   input wire logic vin_interrupt_i,
   // external status sources and restart request
   input wire logic vout_ov_fault_i,
   input wire logic vin_ov_warn_i,
   input wire logic share_fault_i,
   input wire logic pwr_limit_i,
   input wire logic [1:0] fan_fault_i,
   input wire logic [1:0] fan_override_i,
   input wire logic busy_i,
   input wire logic pg_n_i,
   input wire logic mfr_event_i,
   input wire logic pec_error_i,
   input wire logic comm_other_i,
   input wire logic restart_i,
   // alert and power control
   output logic alert_n_o,
   output logic output_off_o
);

   // the fixed low-line warning must not sit above the fixed low-line limit
   if (LOWLINE_CUR_WARN > LOWLINE_CUR_LIMIT) begin : g_chk
      $error("low-line warning above low-line limit");
   end

   logic wr, rd, clr;
   logic [7:0] code;
   logic [15:0] wd;
   logic [15:0] vovw_ff, vuvw_ff, vuvf_ff, iocf_ff, iocw_ff;
   logic [15:0] totf_ff, totw_ff, novf_ff, nuvw_ff, nuvf_ff;
   logic [7:0] vuva_ff, ioca_ff, tota_ff, nova_ff, nuva_ff;
   logic [7:0] svout_ff, siout_ff, sin_ff, stemp_ff, scomm_ff, sfan_ff;
   logic [7:0] set_vout, set_iout, set_in, set_temp, set_comm, set_fan;
   logic [7:0] nxt_svout, nxt_siout, nxt_sin, nxt_stemp, nxt_scomm, nxt_sfan;
   logic [7:0] sum_lo;
   logic [7:0] sum_hi;
   logic [15:0] nxt_rdata;
   logic [4:0] latch_ff;
   logic [4:0] trip, lk;
   logic known, is_ro, is_act, bad_cmd, bad_data;
   logic c_vovw, c_vuvw, c_vuvf, c_curlim, c_curlow, c_curw;
   logic c_totf, c_totw, c_novf, c_nuvw, c_nuvf;
   logic [15:0] cur_lim, cur_warn;
   logic alert_n_ff, off_ff, rvalid_ff;
   logic [15:0] rdata_ff;

   // only writes taken while enabled count
   assign wr = ce_i & cmd_i.wr;
   assign rd = ce_i & cmd_i.rd;
   assign code = cmd_i.code;
   assign wd = cmd_i.data;
   // a host not in control cannot clear anything
   assign clr = wr & (code == `PFLS_CMD_CLEAR) & in_control_i;

   // response code check: overcurrent takes hiccup or restart, all others latch or restart
   function automatic logic act_ok(input logic [7:0] c, input logic [7:0] v);
      logic ok;
      ok = 1'b0;
      if (c == `PFLS_CMD_IOCA) begin
         ok = (v == `PFLS_ACT_HICCUP) || (v == `PFLS_ACT_RESTART);
      end else if (c == `PFLS_CMD_TOTA) begin
         ok = (v == `PFLS_ACT_RESTART) || (v == `PFLS_ACT_LATCH);
      end else begin
         ok = (v == `PFLS_ACT_LATCH) || (v == `PFLS_ACT_RESTART);
      end
      return ok;
   endfunction

   // latch-off code differs per register; overcurrent latches on 0xC0
   function automatic pfls_act_t act_kind(input logic [7:0] latch_code, input logic [7:0] v);
      pfls_act_t k;
      k = (v == latch_code) ? PFLS_LATCH : PFLS_RETRY;
      return k;
   endfunction

   // command classification
   always_comb begin
      is_act = (code == `PFLS_CMD_VUVA) || (code == `PFLS_CMD_IOCA) ||
               (code == `PFLS_CMD_TOTA) || (code == `PFLS_CMD_NOVA) ||
               (code == `PFLS_CMD_NUVA);
      is_ro = (code >= `PFLS_CMD_SBYTE && code <= `PFLS_CMD_SCOMM) ||
              (code == `PFLS_CMD_SFAN);
      known = is_act || is_ro ||
              (code == `PFLS_CMD_VOVW) || (code == `PFLS_CMD_VUVW) ||
              (code == `PFLS_CMD_VUVF) || (code == `PFLS_CMD_IOCF) ||
              (code == `PFLS_CMD_IOCW) || (code == `PFLS_CMD_TOTF) ||
              (code == `PFLS_CMD_TOTW) || (code == `PFLS_CMD_NOVF) ||
              (code == `PFLS_CMD_NUVW) || (code == `PFLS_CMD_NUVF);
      // clear is write-only; status registers are read-only
      bad_cmd = (rd & ~known) | (wr & ~known & (code != `PFLS_CMD_CLEAR)) | (wr & is_ro);
      bad_data = wr & is_act & ~act_ok(code, wd[7:0]);
   end

   // limit registers; widths are full words, no range check on limits
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         vovw_ff <= `PFLS_RST_HI_LIM;
         vuvw_ff <= `PFLS_RST_LO_LIM;
         vuvf_ff <= `PFLS_RST_LO_LIM;
         iocf_ff <= `PFLS_RST_HI_LIM;
         iocw_ff <= `PFLS_RST_HI_LIM;
         totf_ff <= `PFLS_RST_HI_LIM;
         totw_ff <= `PFLS_RST_HI_LIM;
         novf_ff <= `PFLS_RST_HI_LIM;
         nuvw_ff <= `PFLS_RST_LO_LIM;
         nuvf_ff <= `PFLS_RST_LO_LIM;
      end else if (wr) begin
         if (code == `PFLS_CMD_VOVW) begin
            vovw_ff <= wd;
         end else if (code == `PFLS_CMD_VUVW) begin
            vuvw_ff <= wd;
         end else if (code == `PFLS_CMD_VUVF) begin
            vuvf_ff <= wd;
         end else if (code == `PFLS_CMD_IOCF) begin
            iocf_ff <= wd;
         end else if (code == `PFLS_CMD_IOCW) begin
            iocw_ff <= wd;
         end else if (code == `PFLS_CMD_TOTF) begin
            totf_ff <= wd;
         end else if (code == `PFLS_CMD_TOTW) begin
            totw_ff <= wd;
         end else if (code == `PFLS_CMD_NOVF) begin
            novf_ff <= wd;
         end else if (code == `PFLS_CMD_NUVW) begin
            nuvw_ff <= wd;
         end else if (code == `PFLS_CMD_NUVF) begin
            nuvf_ff <= wd;
         end
      end
   end

   // response registers; a refused code leaves the old setting
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         vuva_ff <= `PFLS_RST_VUVA;
         ioca_ff <= `PFLS_RST_IOCA;
         tota_ff <= `PFLS_RST_TOTA;
         nova_ff <= `PFLS_RST_NOVA;
         nuva_ff <= `PFLS_RST_NUVA;
      end else if (wr && is_act && !bad_data) begin
         if (code == `PFLS_CMD_VUVA) begin
            vuva_ff <= wd[7:0];
         end else if (code == `PFLS_CMD_IOCA) begin
            ioca_ff <= wd[7:0];
         end else if (code == `PFLS_CMD_TOTA) begin
            tota_ff <= wd[7:0];
         end else if (code == `PFLS_CMD_NOVA) begin
            nova_ff <= wd[7:0];
         end else begin
            nuva_ff <= wd[7:0];
         end
      end
   end

   // fault and warning conditions from the live measurements
   always_comb begin
      cur_lim = high_line_i ? iocf_ff : LOWLINE_CUR_LIMIT;
      cur_warn = high_line_i ? iocw_ff : LOWLINE_CUR_WARN;
      c_vovw = meas_i.vout > vovw_ff;
      c_vuvw = meas_i.vout < vuvw_ff;
      // an input dropout also pulls vout down; that is not an output fault
      c_vuvf = (meas_i.vout < vuvf_ff) & ~vin_interrupt_i;
      c_curlim = meas_i.iout > cur_lim;
      c_curlow = c_curlim & (meas_i.vout < LOW_OUT_THRESH);
      c_curw = meas_i.iout > cur_warn;
      c_totf = meas_i.temp > totf_ff;
      c_totw = meas_i.temp > totw_ff;
      c_novf = meas_i.vin > novf_ff;
      c_nuvw = meas_i.vin < nuvw_ff;
      c_nuvf = meas_i.vin < nuvf_ff;
   end

   // set vectors; reserved positions stay zero
   assign set_vout = {vout_ov_fault_i, c_vovw, c_vuvw, c_vuvf, 4'h0};
   assign set_iout = {c_curlim, c_curlow, c_curw, 1'b0, share_fault_i, pwr_limit_i,
                      2'h0};
   assign set_in = {c_novf, vin_ov_warn_i, c_nuvw, c_nuvf, c_nuvf, 3'h0};
   assign set_temp = {c_totf, c_totw, 6'h00};
   assign set_comm = {bad_cmd, bad_data, pec_error_i, 3'h0, comm_other_i, 1'b0};
   assign set_fan = {fan_fault_i[0], fan_fault_i[1], 2'h0, fan_override_i[0],
                     fan_override_i[1], 2'h0};

   // sticky update: a set in the clearing cycle survives
   always_comb begin
      nxt_svout = (svout_ff & ~{8{clr}}) | set_vout;
      nxt_siout = (siout_ff & ~{8{clr}}) | set_iout;
      nxt_sin = (sin_ff & ~{8{clr}}) | set_in;
      nxt_stemp = (stemp_ff & ~{8{clr}}) | set_temp;
      nxt_scomm = (scomm_ff & ~{8{clr}}) | set_comm;
      nxt_sfan = (sfan_ff & ~{8{clr}}) | set_fan;
   end

   // category status bytes
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         svout_ff <= `PFLS_RST_STAT;
         siout_ff <= `PFLS_RST_STAT;
         sin_ff <= `PFLS_RST_STAT;
         stemp_ff <= `PFLS_RST_STAT;
         scomm_ff <= `PFLS_RST_STAT;
         sfan_ff <= `PFLS_RST_STAT;
      end else if (ce_i) begin
         svout_ff <= nxt_svout;
         siout_ff <= nxt_siout;
         sin_ff <= nxt_sin;
         stemp_ff <= nxt_stemp;
         scomm_ff <= nxt_scomm;
         sfan_ff <= nxt_sfan;
      end
   end

   // shutdown sources: vout uv, current low-voltage, temp, vin ov, vin uv
   assign trip = {c_vuvf, c_curlow, c_totf, c_novf, c_nuvf};

   // which trips latch off; overcurrent latches on 0xC0, the others on 0x80
   assign lk = {act_kind(`PFLS_ACT_LATCH, vuva_ff) == PFLS_LATCH,
                act_kind(`PFLS_ACT_RESTART, ioca_ff) == PFLS_LATCH,
                act_kind(`PFLS_ACT_LATCH, tota_ff) == PFLS_LATCH,
                act_kind(`PFLS_ACT_LATCH, nova_ff) == PFLS_LATCH,
                act_kind(`PFLS_ACT_LATCH, nuva_ff) == PFLS_LATCH};

   // latch-off memory, only a restart request releases it
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         latch_ff <= 5'h00;
      end else if (ce_i) begin
         if (restart_i) begin
            latch_ff <= 5'h00;
         end else begin
            latch_ff <= latch_ff | (trip & lk);
         end
      end
   end

   // output off follows live trips in retry modes; retry timing lives outside
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         off_ff <= 1'b0;
      end else if (ce_i) begin
         off_ff <= (|trip) | (|latch_ff) | vout_ov_fault_i;
      end
   end

   // summary byte and word high byte from the category bytes plus busy_i, off_ff, mfr_event_i and pg_n_i
   always_comb begin
      sum_hi = 8'h00;
      sum_hi[`PFLS_W_VOUT] = |svout_ff;
      sum_hi[`PFLS_W_IOUT] = |siout_ff;
      sum_hi[`PFLS_W_IN] = |sin_ff;
      sum_hi[`PFLS_W_MFR] = mfr_event_i;
      sum_hi[`PFLS_W_PGN] = pg_n_i;
      sum_hi[`PFLS_W_FAN] = |sfan_ff;
      sum_lo = 8'h00;
      sum_lo[`PFLS_B_BUSY] = busy_i;
      sum_lo[`PFLS_B_OFF] = off_ff;
      sum_lo[`PFLS_B_VOV] = svout_ff[7];
      sum_lo[`PFLS_B_IOC] = siout_ff[7];
      sum_lo[`PFLS_B_VIN] = sin_ff[4];
      sum_lo[`PFLS_B_TMP] = |stemp_ff;
      sum_lo[`PFLS_B_CML] = |scomm_ff;
      sum_lo[`PFLS_B_NONE] = (|sum_hi) & ~(|sum_lo[7:1]);
   end

   // read mux
   always_comb begin
      nxt_rdata = 16'h0000;
      if (code == `PFLS_CMD_VOVW) begin
         nxt_rdata = vovw_ff;
      end else if (code == `PFLS_CMD_VUVW) begin
         nxt_rdata = vuvw_ff;
      end else if (code == `PFLS_CMD_VUVF) begin
         nxt_rdata = vuvf_ff;
      end else if (code == `PFLS_CMD_VUVA) begin
         nxt_rdata = {8'h00, vuva_ff};
      end else if (code == `PFLS_CMD_IOCF) begin
         nxt_rdata = iocf_ff;
      end else if (code == `PFLS_CMD_IOCA) begin
         nxt_rdata = {8'h00, ioca_ff};
      end else if (code == `PFLS_CMD_IOCW) begin
         nxt_rdata = iocw_ff;
      end else if (code == `PFLS_CMD_TOTF) begin
         nxt_rdata = totf_ff;
      end else if (code == `PFLS_CMD_TOTA) begin
         nxt_rdata = {8'h00, tota_ff};
      end else if (code == `PFLS_CMD_TOTW) begin
         nxt_rdata = totw_ff;
      end else if (code == `PFLS_CMD_NOVF) begin
         nxt_rdata = novf_ff;
      end else if (code == `PFLS_CMD_NOVA) begin
         nxt_rdata = {8'h00, nova_ff};
      end else if (code == `PFLS_CMD_NUVW) begin
         nxt_rdata = nuvw_ff;
      end else if (code == `PFLS_CMD_NUVF) begin
         nxt_rdata = nuvf_ff;
      end else if (code == `PFLS_CMD_NUVA) begin
         nxt_rdata = {8'h00, nuva_ff};
      end else if (code == `PFLS_CMD_SBYTE) begin
         nxt_rdata = {8'h00, sum_lo};
      end else if (code == `PFLS_CMD_SWORD) begin
         nxt_rdata = {sum_hi, sum_lo};
      end else if (code == `PFLS_CMD_SVOUT) begin
         nxt_rdata = {8'h00, svout_ff};
      end else if (code == `PFLS_CMD_SIOUT) begin
         nxt_rdata = {8'h00, siout_ff};
      end else if (code == `PFLS_CMD_SIN) begin
         nxt_rdata = {8'h00, sin_ff};
      end else if (code == `PFLS_CMD_STEMP) begin
         nxt_rdata = {8'h00, stemp_ff};
      end else if (code == `PFLS_CMD_SCOMM) begin
         nxt_rdata = {8'h00, scomm_ff};
      end else if (code == `PFLS_CMD_SFAN) begin
         nxt_rdata = {8'h00, sfan_ff};
      end
   end

   // read answer one cycle after the request; unknown codes answer zero
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rdata_ff <= 16'h0000;
         rvalid_ff <= 1'b0;
      end else if (ce_i) begin
         rvalid_ff <= cmd_i.rd;
         if (cmd_i.rd) begin
            rdata_ff <= nxt_rdata;
         end
      end
   end

   // alert from the next status, so it tracks the sticky bytes exactly
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         alert_n_ff <= 1'b1;
      end else if (ce_i) begin
         alert_n_ff <= ~(|{nxt_svout, nxt_siout, nxt_sin, nxt_stemp, nxt_scomm,
                           nxt_sfan});
      end
   end

   assign alert_n_o = alert_n_ff;
   assign output_off_o = off_ff;
   assign rdata_o = rdata_ff;
   assign rvalid_o = rvalid_ff;

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!arst_n_i);

   high_warn_alert_a: assert property (ce_i && c_vovw |=> !alert_n_o && svout_ff[6])
      else $error("vout high warning did not raise alert");
   low_warn_alert_a: assert property (ce_i && c_vuvw |=> !alert_n_o && svout_ff[5])
      else $error("vout low warning did not raise alert");
   uv_shutdown_a: assert property (ce_i && c_vuvf |=> output_off_o && svout_ff[4])
      else $error("vout undervoltage did not shut down");
   act_refuse_a: assert property (bad_data |=> $stable({vuva_ff, ioca_ff, tota_ff, nova_ff,
                                  nuva_ff}) && scomm_ff[6])
      else $error("bad response code was taken or not flagged");
   cur_low_off_a: assert property (ce_i && c_curlow |=> output_off_o && siout_ff[6])
      else $error("current low-voltage fault did not shut down");
   cur_only_a: assert property (ce_i && c_curlim && !c_curlow && !(|latch_ff) && !vout_ov_fault_i
                                && !(|trip) |=> !output_off_o)
      else $error("current limit alone shut the output down");
   temp_fault_a: assert property (ce_i && c_totf |=> output_off_o && stemp_ff[7])
      else $error("overtemperature not acted on");
   temp_latch_a: assert property (ce_i && c_totf && tota_ff == `PFLS_ACT_LATCH && !restart_i
                                  |=> latch_ff[2] ##1 (latch_ff[2] || $past(restart_i)))
      else $error("overtemperature latch did not hold");
   clear_release_a: assert property (ce_i && clr && !(|{set_vout, set_iout, set_in, set_temp,
                                     set_comm, set_fan}) |=> alert_n_o)
      else $error("clear did not release alert");
   alert_tie_a: assert property (alert_n_o == !(|{svout_ff, siout_ff, sin_ff, stemp_ff,
                                 scomm_ff, sfan_ff}))
      else $error("alert does not match status");
   word_vout_a: assert property (ce_i && c_vovw ##1 ce_i && rd && code == `PFLS_CMD_SWORD
                                 |=> rdata_o[15] && rvalid_o)
      else $error("word category bit missing");

   clear_c: cover property (clr ##1 alert_n_o);
   latch_c: cover property (c_totf && tota_ff == `PFLS_ACT_LATCH ##1 latch_ff[2]);
   cur_low_c: cover property (c_curlow ##1 output_off_o);
   bad_data_c: cover property (bad_data ##1 scomm_ff[6]);

endmodule

// ==== inc/pfls_map.svh ====
`ifndef PFLS_MAP_SVH
`define PFLS_MAP_SVH
// command codes
`define PFLS_CMD_CLEAR 8'h03
`define PFLS_CMD_VOVW 8'h42
`define PFLS_CMD_VUVW 8'h43
`define PFLS_CMD_VUVF 8'h44
`define PFLS_CMD_VUVA 8'h45
`define PFLS_CMD_IOCF 8'h46
`define PFLS_CMD_IOCA 8'h47
`define PFLS_CMD_IOCW 8'h4A
`define PFLS_CMD_TOTF 8'h4F
`define PFLS_CMD_TOTA 8'h50
`define PFLS_CMD_TOTW 8'h51
`define PFLS_CMD_NOVF 8'h55
`define PFLS_CMD_NOVA 8'h56
`define PFLS_CMD_NUVW 8'h58
`define PFLS_CMD_NUVF 8'h59
`define PFLS_CMD_NUVA 8'h5A
`define PFLS_CMD_SBYTE 8'h78
`define PFLS_CMD_SWORD 8'h79
`define PFLS_CMD_SVOUT 8'h7A
`define PFLS_CMD_SIOUT 8'h7B
`define PFLS_CMD_SIN 8'h7C
`define PFLS_CMD_STEMP 8'h7D
`define PFLS_CMD_SCOMM 8'h7E
`define PFLS_CMD_SFAN 8'h81
// response codes
`define PFLS_ACT_LATCH 8'h80
`define PFLS_ACT_RESTART 8'hC0
`define PFLS_ACT_HICCUP 8'hF8
// reset values
`define PFLS_RST_VUVA 8'hC0
`define PFLS_RST_IOCA 8'hF8
`define PFLS_RST_TOTA 8'hC0
`define PFLS_RST_NOVA 8'hC0
`define PFLS_RST_NUVA 8'hC0
`define PFLS_RST_HI_LIM 16'hFFFF
`define PFLS_RST_LO_LIM 16'h0000
`define PFLS_RST_STAT 8'h00
// field positions
`define PFLS_B_BUSY 7
`define PFLS_B_OFF 6
`define PFLS_B_VOV 5
`define PFLS_B_IOC 4
`define PFLS_B_VIN 3
`define PFLS_B_TMP 2
`define PFLS_B_CML 1
`define PFLS_B_NONE 0
`define PFLS_W_VOUT 7
`define PFLS_W_IOUT 6
`define PFLS_W_IN 5
`define PFLS_W_MFR 4
`define PFLS_W_PGN 3
`define PFLS_W_FAN 2
`endif

// ==== inc/pfls_pkg.sv ====
package pfls_pkg;
   // sensed quantities, one word each
   typedef struct packed {
      logic [15:0] vout;
      logic [15:0] iout;
      logic [15:0] temp;
      logic [15:0] vin;
   } pfls_meas_t;
   // one command transfer from the management bus front end
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] code;
      logic [15:0] data;
   } pfls_cmd_t;
   typedef enum logic {PFLS_LATCH, PFLS_RETRY} pfls_act_t;
endpackage

// ==== test/pfls_host.sv ====
module pfls_host
   import pfls_pkg::*;
(
   // bus side
   input wire logic sys_clk_i,
   input wire logic [15:0] rdata_i,
   input wire logic rvalid_i,
   output pfls_cmd_t cmd_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic hung;
   // idle bus and no hang seen yet
   initial begin
      cmd_o = '0;
      hung = 1'b0;
   end
   // one transfer: strobe for one cycle, then on a read wait a bounded time for the answer
   task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
         output logic [15:0] q);
      int n;
      @(negedge sys_clk_i);
      cmd_o = '{wr: w, rd: !w, code: c, data: d};
      @(negedge sys_clk_i);
      // released fields flip so a stale value is never mistaken for a live one
      cmd_o = '{wr: 1'b0, rd: 1'b0, code: ~c, data: ~d};
      n = 0;
      while (!w && rvalid_i !== 1'b1 && n < 4) begin
         @(negedge sys_clk_i);
         n++;
      end
      hung = hung | (n == 4);
      q = rdata_i;
   endtask
endmodule

// ==== test/pfls_bank_tb.sv ====
module pfls_bank_tb;
   import pfls_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   // code and value after reset, response registers first
   localparam logic [23:0] RST [13] = '{24'h4500C0, 24'h4700F8, 24'h5000C0, 24'h5600C0,
      24'h5A00C0, 24'h780000, 24'h790000, 24'h7A0000, 24'h7B0000, 24'h7C0000, 24'h7D0000,
      24'h7E0000, 24'h810000};
   // limit code, field, trips above, status code, status value, shuts off
   localparam logic [27:0] LIM [10] = '{{8'h42, 2'h3, 1'h1, 8'h7A, 8'h40, 1'h0},
      {8'h43, 2'h3, 1'h0, 8'h7A, 8'h20, 1'h0}, {8'h44, 2'h3, 1'h0, 8'h7A, 8'h10, 1'h1},
      {8'h4F, 2'h1, 1'h1, 8'h7D, 8'h80, 1'h1}, {8'h51, 2'h1, 1'h1, 8'h7D, 8'h40, 1'h0},
      {8'h55, 2'h0, 1'h1, 8'h7C, 8'h80, 1'h1}, {8'h58, 2'h0, 1'h0, 8'h7C, 8'h20, 1'h0},
      {8'h59, 2'h0, 1'h0, 8'h7C, 8'h18, 1'h1}, {8'h4A, 2'h2, 1'h1, 8'h7B, 8'h20, 1'h0},
      {8'h46, 2'h2, 1'h1, 8'h7B, 8'h80, 1'h0}};
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic ctl = 1'b1;
   logic rstrt = 1'b0;
   logic hl = 1'b1;
   logic vint = 1'b0;
   logic en = 1'b1;
   logic [12:0] ext = '0;
   // fixed low-line levels and sag threshold handed to the design
   localparam logic [15:0] LL_LIM = 16'h0200;
   localparam logic [15:0] LL_WARN = 16'h01C0;
   localparam logic [15:0] LV_TH = 16'h0100;
   logic [15:0] rdata, q, lim;
   logic rvalid, alert_n, off, up, o;
   logic [7:0] c, sc, sv;
   logic [1:0] f;
   pfls_meas_t meas = {4{16'h8000}};
   pfls_cmd_t cmd;
   int n_errors = 0;
   int total_checks = 0;
   int seed = 32'hbee8;
   // 25 MHz
   always #20 clk = ~clk;
   pfls_bank #(.LOWLINE_CUR_LIMIT(LL_LIM), .LOWLINE_CUR_WARN(LL_WARN), .LOW_OUT_THRESH(LV_TH))
      pfls_bank_i (.sys_clk_i(clk), .arst_n_i(rst_n), .ce_i(en), .cmd_i(cmd),
      .in_control_i(ctl), .rdata_o(rdata), .rvalid_o(rvalid), .meas_i(meas),
      .high_line_i(hl), .vin_interrupt_i(vint), .vout_ov_fault_i(ext[9]),
      .vin_ov_warn_i(ext[8]), .share_fault_i(ext[7]), .pwr_limit_i(ext[6]),
      .fan_fault_i(ext[5:4]), .fan_override_i(ext[3:2]), .busy_i(ext[10]), .pg_n_i(ext[11]),
      .mfr_event_i(ext[12]), .pec_error_i(ext[1]), .comm_other_i(ext[0]), .restart_i(rstrt),
      .alert_n_o(alert_n), .output_off_o(off));
   pfls_host pfls_host_i (.sys_clk_i(clk), .rdata_i(rdata), .rvalid_i(rvalid), .cmd_o(cmd));
   // status code and value each external source should raise
   function automatic logic [23:0] ext_exp(input int i);
      case (i)
         0: return 24'h7E0002;
         1: return 24'h7E0020;
         2: return 24'h810008;
         3: return 24'h810004;
         4: return 24'h810080;
         5: return 24'h810040;
         6: return 24'h7B0004;
         7: return 24'h7B0008;
         8: return 24'h7C0040;
         9: return 24'h7A0080;
         11: return 24'h790801;
         12: return 24'h791001;
         default: return 24'h780080;
      endcase
   endfunction
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] code, input logic [15:0] d);
      logic [15:0] t;
      pfls_host_i.xfer(1'b1, code, d, t);
   endtask
   // a hung read ends the run at once
   task automatic rd(input logic [7:0] code);
      pfls_host_i.xfer(1'b0, code, 16'h0000, q);
      if (pfls_host_i.hung) begin
         n_errors++;
         print_verdict();
      end
   endtask
   task automatic clr();
      wr(8'h03, 16'h0000);
   endtask
   // watchdog against a stuck sequence
   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      print_verdict();
   end
   // main sequence
   initial begin
      repeat (16) @(negedge clk);
      rst_n = 1'b1;
      check(16'(alert_n), 16'h0001);
      for (int i = 0; i < 13; i++) begin
         rd(RST[i][23:16]);
         check(q, RST[i][15:0]);
      end
      // a write while disabled leaves the limit alone
      en = 1'b0;
      wr(8'h42, 16'h0000);
      en = 1'b1;
      rd(8'h42);
      check(q, 16'hFFFF);
      rd(8'h03);
      check(q, 16'h0000);
      rd(8'h7E);
      check(q, 16'h0080);
      clr();
      // bad response codes dropped, then the other legal code sticks
      for (int i = 0; i < 5; i++) begin
         c = RST[i][23:16];
         sv = 8'($random(seed));
         if (sv inside {8'h80, 8'hC0, 8'hF8}) sv = 8'h11;
         wr(c, {8'h00, sv});
         rd(c);
         check(q, RST[i][15:0]);
         rd(8'h7E);
         check(q, 16'h0040);
         clr();
         sv = (c == 8'h47) ? 8'hC0 : 8'h80;
         wr(c, {8'h00, sv});
         rd(c);
         check(q, {8'h00, sv});
         wr(c, RST[i][15:0]);
      end
      // codes legal for some response registers but refused by others
      wr(8'h45, 16'h00F8);
      rd(8'h45);
      check(q, 16'h00C0);
      wr(8'h47, 16'h0080);
      rd(8'h47);
      check(q, 16'h00F8);
      rd(8'h7E);
      check(q, 16'h0040);
      clr();
      // each limit at a random level, crossed by one count
      for (int i = 0; i < 10; i++) begin
         {c, f, up, sc, sv, o} = LIM[i];
         lim = 16'h1000 + (16'($random(seed)) & 16'hDFFF);
         wr(c, lim);
         meas[f*16 +: 16] = up ? lim + 16'h0001 : lim - 16'h0001;
         repeat (3) @(negedge clk);
         rd(sc);
         check(q, {8'h00, sv});
         check(16'(alert_n), 16'h0000);
         check(16'(off), 16'(o));
         if (i == 0) begin
            rd(8'h79);
            check(q, 16'h8001);
         end
         clr();
         rd(sc);
         check(q, {8'h00, sv});
         wr(c, up ? 16'hFFFF : 16'h0000);
         meas[f*16 +: 16] = 16'h8000;
         ctl = 1'b0;
         clr();
         check(16'(alert_n), 16'h0000);
         ctl = 1'b1;
         clr();
         repeat (2) @(negedge clk);
         check(16'(alert_n), 16'h0001);
      end
      // latch-off outlives a clear, only a restart releases it
      wr(8'h50, 16'h0080);
      wr(8'h4F, 16'h4000);
      meas.temp = 16'h4001;
      repeat (3) @(negedge clk);
      wr(8'h4F, 16'hFFFF);
      clr();
      repeat (2) @(negedge clk);
      check(16'(off), 16'h0001);
      rstrt = 1'b1;
      @(negedge clk);
      rstrt = 1'b0;
      repeat (2) @(negedge clk);
      check(16'(off), 16'h0000);
      wr(8'h50, 16'h00C0);
      // an input dropout masks the output undervoltage fault
      vint = 1'b1;
      wr(8'h44, 16'h9000);
      repeat (3) @(negedge clk);
      check(16'(off), 16'h0000);
      rd(8'h7A);
      check(q, 16'h0000);
      vint = 1'b0;
      repeat (3) @(negedge clk);
      check(16'(off), 16'h0001);
      rd(8'h7A);
      check(q, 16'h0010);
      wr(8'h44, 16'h0000);
      clr();
      // low line: fixed levels rule, the writable limit is ignored
      meas.iout = LL_WARN + 16'h0001;
      hl = 1'b0;
      wr(8'h46, 16'h0100);
      repeat (3) @(negedge clk);
      rd(8'h7B);
      check(q, 16'h0020);
      meas.iout = LL_LIM + 16'h0001;
      meas.vout = LV_TH - 16'h0001;
      repeat (3) @(negedge clk);
      check(16'(off), 16'h0001);
      rd(8'h7B);
      check(q, 16'h00E0);
      meas = {4{16'h8000}};
      hl = 1'b1;
      wr(8'h46, 16'hFFFF);
      clr();
      // one external source at a time
      for (int i = 0; i < 13; i++) begin
         ext = 13'(1 << i);
         repeat (3) @(negedge clk);
         {sc, lim} = ext_exp(i);
         rd(sc);
         check(q, lim);
         ext = '0;
         rstrt = 1'b1;
         clr();
         rstrt = 1'b0;
      end
      print_verdict();
   end
endmodule
